// ---- hw/wdt_unit.sv ----
// file: watchdog timer unit on the processor sfr bus
`timescale 1ns/1ps
// Overview of operation
// RULE1 - free up-counter sets flag at selected interval
// RULE2 - select codes give 2^17,2^20,2^23,2^26 clocks
// RULE3 - select at clock control bits 7:6, reset 0x03
// RULE4 - irq needs flag, enable bit and global enable
// RULE5 - reset 512 clocks after flag unless restarted
// RULE6 - reset enable gates reset only, not irq
// RULE7 - restart bit zeroes count, self clears
// RULE8 - cause flag set by watchdog reset or by a keyed software write
// RULE9 - irq flag sticky until software or reset
// RULE10 - software-set flag interrupts like timeout
// RULE11 - control write needs 0xAA then 0x55 unlock
// RULE12 - watchdog reset keeps settings, counter restarts
// RULE13 - flag still sets with everything disabled
// RULE14 - counter and delay clocked directly by mclk
// RULE15 - priority bit sets watchdog irq level
// RULE16 - unlocked-less control write is ignored
module wdt_unit
    import wdt_pkg::*;
#(
    parameter int CNT_WIDTH = wdt_pkg::CNT_W      // counter width
) (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrEn,
    input  wire logic [7:0] sfrWrData,
    output logic      [7:0] sfrRdData,
    input  wire logic [7:0] extIrqEnableReg,
    input  wire logic [7:0] extIrqPriorityReg,
    input  wire logic       globalIrqEnable,
    output logic            wdogIrqReq,
    output logic            wdogIrqPriority,
    output logic            wdogResetReq
);
    import wdt_pkg::*;

    logic [7:0]           clkCtrl_r;          // clock control register
    logic                 rstEn_r;            // reset on timeout enable
    logic                 rstCause_r;         // reset cause flag
    logic                 irqFlag_r;          // timeout irq flag
    logic [CNT_WIDTH-1:0] count_r;            // free running counter
    logic                 pending_r;          // reset delay armed
    logic [DLY_W-1:0]     delay_r;            // reset delay counter
    logic                 rstPulse_r;         // registered reset request
    wdt_key_t             key_r;              // unlock sequence state
    wdt_key_t             key_nxt;

    // intervals are exact powers of two, so one equality compare per edge is all it costs
    // interval lookup, one place for the select encoding
    function automatic logic [CNT_WIDTH-1:0] intervalOf(input logic [1:0] sel);
        case (sel)
            2'b00:   intervalOf = CNT_WIDTH'(IVL_SEL0);
            2'b01:   intervalOf = CNT_WIDTH'(IVL_SEL1);
            2'b10:   intervalOf = CNT_WIDTH'(IVL_SEL2);
            default: intervalOf = CNT_WIDTH'(IVL_SEL3);
        endcase
    endfunction : intervalOf

    // decode
    wire        hitClk   = sfrWrEn && (sfrAddr == ADDR_CLK_CTRL);
    wire        hitKey   = sfrWrEn && (sfrAddr == ADDR_TA_KEY);
    wire        hitCtrl  = sfrWrEn && (sfrAddr == ADDR_WDOG_CTRL);
    wire        ctrlWrOk = hitCtrl && (key_r == KEY_OPEN);           // see RULE11 see RULE16
    wire        restart  = ctrlWrOk && sfrWrData[BIT_RESTART];        // see RULE7
    wire [1:0]  sel      = clkCtrl_r[SEL_HI_BIT:SEL_LO_BIT];          // see RULE3
    wire        timeout  = (count_r == intervalOf(sel) - CNT_WIDTH'(1)); // see RULE1 see RULE2
    wire        delayEnd = pending_r && (delay_r == DLY_W'(RST_DELAY_CLKS - 1)); // see RULE5
    wire        fireRst  = delayEnd && rstEn_r && !restart;           // see RULE6

    // key sequence: any sfr write that is not the next step drops the unlock
    // limitation: firmware must keep interrupts from writing sfrs between the key bytes
    always_comb begin
        key_nxt = key_r;
        if (sfrWrEn) begin
            if (hitKey && sfrWrData == KEY_FIRST) begin
                key_nxt = KEY_GOT_AA;
            end else if (hitKey && sfrWrData == KEY_SECOND && key_r == KEY_GOT_AA) begin
                key_nxt = KEY_OPEN;
            end else begin
                key_nxt = KEY_IDLE;                                  // see RULE16
            end
        end
    end

    // read mux; unimplemented bits read zero
    // the restart bit is only a strobe, so it never reads back as set
    always_comb begin
        if (sfrAddr == ADDR_CLK_CTRL) begin
            sfrRdData = clkCtrl_r;
        end else if (sfrAddr == ADDR_WDOG_CTRL) begin
            sfrRdData = {4'h0, irqFlag_r, rstCause_r, rstEn_r, 1'b0}; // restart reads 0
        end else begin
            sfrRdData = 8'h00;
        end
    end

    assign wdogIrqReq      = irqFlag_r && extIrqEnableReg[EIE_WDOG_BIT]
                             && globalIrqEnable;                       // see RULE4 see RULE10
    assign wdogIrqPriority = extIrqPriorityReg[EIP_WDOG_BIT];          // see RULE15
    assign wdogResetReq    = rstPulse_r;

    // sfr registers; our own reset request does not clear settings
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            clkCtrl_r <= CLK_CTRL_RESET;
            rstEn_r   <= 1'b0;
            key_r     <= KEY_IDLE;
        end else begin
            key_r <= key_nxt;
            if (hitClk) begin
                clkCtrl_r <= sfrWrData;
            end
            if (ctrlWrOk) begin
                rstEn_r <= sfrWrData[BIT_RST_EN];                    // see RULE12
            end
        end
    end

    // flags: hardware set wins over a software clear in the same cycle
    // a clear that loses to a timeout must be repeated, but no timeout is ever missed
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irqFlag_r  <= 1'b0;
            rstCause_r <= 1'b0;                                       // see RULE8
        end else begin
            if (timeout) begin
                irqFlag_r <= 1'b1;                                    // see RULE1 see RULE13
            end else if (ctrlWrOk) begin
                irqFlag_r <= sfrWrData[BIT_IRQ_FLAG];                 // see RULE9 see RULE10
            end
            if (fireRst) begin
                rstCause_r <= 1'b1;                                   // see RULE8
            end else if (ctrlWrOk) begin
                rstCause_r <= sfrWrData[BIT_RST_CAUSE];               // write never resets
            end
        end
    end

    // counter and reset delay, both on mclk with no prescaler
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            count_r    <= '0;
            pending_r  <= 1'b0;
            delay_r    <= '0;
            rstPulse_r <= 1'b0;
        end else begin
            rstPulse_r <= fireRst;
            if (restart || fireRst || timeout) begin
                count_r <= '0;                                        // see RULE7 see RULE12 see RULE14
            end else begin
                count_r <= count_r + CNT_WIDTH'(1);
            end
            if (restart || delayEnd) begin
                pending_r <= 1'b0;
                delay_r   <= '0;
            end else if (timeout) begin
                pending_r <= 1'b1;                                    // see RULE5
                delay_r   <= '0;
            end else if (pending_r) begin
                delay_r <= delay_r + DLY_W'(1);                       // see RULE14
            end
        end
    end

    // checker helpers: an age of the last timeout kept apart from delay_r, so the reset timing
    // is judged by an independent count; it saturates at all ones, meaning nothing is armed
    localparam int               AGE_W    = DLY_W + 1;                  // room above the delay
    localparam logic [AGE_W-1:0] AGE_IDLE = '1;                         // saturated, idle
    localparam logic [AGE_W-1:0] AGE_FIRE = AGE_W'(RST_DELAY_CLKS);     // age at the pulse
    localparam logic [AGE_W-1:0] AGE_LAST = AGE_W'(RST_DELAY_CLKS - 1); // age one before it
    logic [AGE_W-1:0]            flagAge_r;                             // cycles since timeout

    // age counter: a restart cancels, a timeout starts it at zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            flagAge_r <= AGE_IDLE;
        end else if (restart) begin
            flagAge_r <= AGE_IDLE;                                    // restart wins over timeout
        end else if (timeout) begin
            flagAge_r <= '0;
        end else if (flagAge_r != AGE_IDLE) begin
            flagAge_r <= flagAge_r + AGE_W'(1);                       // stops when saturated
        end
    end

    // checks on what this block drives; all on mclk and quiet while reset is low
    chk_unlock_needed: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE16
        hitCtrl && key_r != KEY_OPEN |=> $stable(rstEn_r))
        else $error("control write without unlock changed reset enable");
    chk_flag_on_timeout: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE1
        timeout |=> irqFlag_r)
        else $error("flag not set on timeout");
    chk_reset_delay: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE5
        wdogResetReq |-> flagAge_r == AGE_FIRE)
        else $error("reset request not 512 clocks after flag");
    chk_reset_on_time: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE5
        flagAge_r == AGE_LAST && rstEn_r && !restart |=> wdogResetReq)
        else $error("no reset request when the reset delay ran out");
    chk_no_rst_disabled: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE6
        !rstEn_r |=> !wdogResetReq)
        else $error("reset with reset disabled");
    chk_cause_on_reset: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE8
        wdogResetReq |-> rstCause_r)
        else $error("cause flag missing on watchdog reset");
    chk_cause_kept: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE8
        !rstEn_r && !ctrlWrOk |=> $stable(rstCause_r))
        else $error("cause flag changed with reset disabled");
    chk_restart_zero: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE7
        restart |=> count_r == '0)
        else $error("restart did not zero the count");
    chk_restart_cancel: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE7
        restart |=> !pending_r)
        else $error("restart left the reset delay armed");
    chk_count_after_rst: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE12
        wdogResetReq |-> count_r == '0)
        else $error("counter not restarted by the watchdog reset");
    chk_irq_gating: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE4
        wdogIrqReq |-> irqFlag_r && extIrqEnableReg[EIE_WDOG_BIT] && globalIrqEnable)
        else $error("irq without flag, enable bit or global enable");
    chk_flag_sticky: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE9
        irqFlag_r && !ctrlWrOk |=> irqFlag_r)
        else $error("flag dropped without software clear");
endmodule : wdt_unit

// ---- hw/wdt_pkg.sv ----
// package: sfr addresses, field positions, reset values and timing constants for the watchdog
package wdt_pkg;
    localparam logic [7:0] ADDR_CLK_CTRL    = 8'h8E;  // clock control register
    localparam logic [7:0] ADDR_TA_KEY      = 8'hC7;  // timed access key register
    localparam logic [7:0] ADDR_WDOG_CTRL   = 8'hD8;  // watchdog control register
    localparam logic [7:0] CLK_CTRL_RESET   = 8'h03;  // clock control reset value
    localparam logic [7:0] WDOG_CTRL_RESET  = 8'h00;  // watchdog control reset value
    localparam logic [7:0] KEY_FIRST        = 8'hAA;  // first unlock byte
    localparam logic [7:0] KEY_SECOND       = 8'h55;  // second unlock byte
    localparam int         SEL_HI_BIT       = 7;      // timeout select msb
    localparam int         SEL_LO_BIT       = 6;      // timeout select lsb
    localparam int         BIT_RESTART      = 0;      // counter restart
    localparam int         BIT_RST_EN       = 1;      // reset on timeout enable
    localparam int         BIT_RST_CAUSE    = 2;      // reset cause flag
    localparam int         BIT_IRQ_FLAG     = 3;      // timeout irq flag
    localparam int         EIE_WDOG_BIT     = 4;      // enable bit in extended enable reg
    localparam int         EIP_WDOG_BIT     = 4;      // priority bit in extended priority reg
    localparam int         CNT_W            = 27;     // wide enough for 2^26
    localparam logic [CNT_W-1:0] IVL_SEL0   = 27'd131072;
    localparam logic [CNT_W-1:0] IVL_SEL1   = 27'd1048576;
    localparam logic [CNT_W-1:0] IVL_SEL2   = 27'd8388608;
    localparam logic [CNT_W-1:0] IVL_SEL3   = 27'd67108864;
    localparam int         RST_DELAY_CLKS   = 512;    // clocks from flag to reset
    localparam int         DLY_W            = 10;     // delay counter width
    // key sequence progress
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_AA, KEY_OPEN} wdt_key_t;
endpackage : wdt_pkg

// ---- verification/wdt_cpu_model.sv ----
// processor core model that drives the watchdog sfr bus and interrupt levels
`timescale 1ns/1ps
module wdt_cpu_model (
    input  wire logic       mclk,
    input  wire logic [7:0] sfrRdData,
    output logic      [7:0] sfrAddr,
    output logic            sfrWrEn,
    output logic      [7:0] sfrWrData,
    output logic      [7:0] extIrqEnableReg,
    output logic      [7:0] extIrqPriorityReg,
    output logic            globalIrqEnable
);
    import wdt_pkg::*;
    // idle bus and all interrupt levels off from time zero
    initial begin
        sfrAddr           = 8'h00;
        sfrWrEn           = 1'b0;
        sfrWrData         = 8'h00;
        extIrqEnableReg   = 8'h00;
        extIrqPriorityReg = 8'h00;
        globalIrqEnable   = 1'b0;
    end
    // one write, held from a falling edge through the rising edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(negedge mclk);
        sfrAddr   = a;
        sfrWrData = dat;
        sfrWrEn   = 1'b1;
        @(negedge mclk);
        sfrWrEn   = 1'b0;
        sfrWrData = ~dat;  // released data never shows the stale byte
    endtask : wr
    // keyed control write; nothing may slip between the key bytes and the write
    task automatic wr_ctrl(input logic [7:0] dat);
        wr(ADDR_TA_KEY, KEY_FIRST);
        wr(ADDR_TA_KEY, KEY_SECOND);
        wr(ADDR_WDOG_CTRL, dat);
    endtask : wr_ctrl
    // read: address set on a falling edge, data taken at the next rising edge
    task automatic rd(input logic [7:0] a, output logic [7:0] dat);
        @(negedge mclk);
        sfrAddr = a;
        @(posedge mclk);
        dat = sfrRdData;
    endtask : rd
    // enable, priority and global levels, settled by the next rising edge
    task automatic lv(input logic [7:0] en, input logic [7:0] pri, input logic gie);
        @(negedge mclk);
        extIrqEnableReg   = en;
        extIrqPriorityReg = pri;
        globalIrqEnable   = gie;
        @(posedge mclk);
    endtask : lv
endmodule : wdt_cpu_model

// ---- verification/watchdog_timer_unit_test.sv ----
// self-checking bench for the watchdog timer unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module watchdog_timer_unit_test;
    import wdt_pkg::*;
    logic       mclk = 1'b0;   // 25 MHz clock
    logic       arst_n = 1'b0; // low for the first two cycles
    logic [7:0] sfrAddr, sfrWrData, sfrRdData, irqEn, irqPri, d;
    logic       sfrWrEn, gie, wdogIrqReq, wdogIrqPriority, wdogResetReq;
    int         failures = 0;    // mismatches
    int         check_count = 0; // comparisons
    int         n;               // cycle counter for timing
    int         rstSeen = 0;     // cycles with reset request high
    always #20 mclk = ~mclk;
    // falling edge sampling keeps the registered pulse count race free
    always @(negedge mclk) if (wdogResetReq === 1'b1) rstSeen++;
    wdt_unit i_wdt_unit (.mclk(mclk), .arst_n(arst_n), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
        .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .extIrqEnableReg(irqEn),
        .extIrqPriorityReg(irqPri), .globalIrqEnable(gie), .wdogIrqReq(wdogIrqReq),
        .wdogIrqPriority(wdogIrqPriority), .wdogResetReq(wdogResetReq));
    wdt_cpu_model i_wdt_cpu_model (.mclk(mclk), .sfrRdData(sfrRdData), .sfrAddr(sfrAddr),
        .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .extIrqEnableReg(irqEn),
        .extIrqPriorityReg(irqPri), .globalIrqEnable(gie));
    // read one register and compare it
    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        i_wdt_cpu_model.rd(a, d);
        `CHK(nm, e, d)
    endtask : rchk
    // reset values and an unmapped address
    task automatic t_reset;
        rchk("clkctrl", ADDR_CLK_CTRL, CLK_CTRL_RESET);
        rchk("wdctrl", ADDR_WDOG_CTRL, WDOG_CTRL_RESET);
        rchk("unmapped", 8'h10, 8'h00);
        $display("test reset done");
    endtask : t_reset
    // unkeyed and broken-key writes dropped; keyed writes, software flag, irq gating
    task automatic t_lock;
        i_wdt_cpu_model.wr(ADDR_WDOG_CTRL, 8'h02);
        rchk("nokey", ADDR_WDOG_CTRL, 8'h00);
        i_wdt_cpu_model.wr(ADDR_TA_KEY, KEY_FIRST);
        i_wdt_cpu_model.wr(ADDR_CLK_CTRL, CLK_CTRL_RESET);
        i_wdt_cpu_model.wr(ADDR_TA_KEY, KEY_SECOND);
        i_wdt_cpu_model.wr(ADDR_WDOG_CTRL, 8'h02);
        rchk("brokenkey", ADDR_WDOG_CTRL, 8'h00);
        i_wdt_cpu_model.wr_ctrl(8'h04);
        rchk("causewr", ADDR_WDOG_CTRL, 8'h04);
        i_wdt_cpu_model.lv(8'h10, 8'h10, 1'b1);
        i_wdt_cpu_model.wr_ctrl(8'h08);
        `CHK("swirq", 1'b1, wdogIrqReq)
        `CHK("prio", 1'b1, wdogIrqPriority)
        i_wdt_cpu_model.lv(8'hEF, 8'hEF, 1'b1);
        `CHK("enoff", 1'b0, wdogIrqReq)
        `CHK("prioff", 1'b0, wdogIrqPriority)
        i_wdt_cpu_model.lv(8'h10, 8'h00, 1'b0);
        `CHK("gieoff", 1'b0, wdogIrqReq)
        i_wdt_cpu_model.lv(8'h10, 8'h00, 1'b1);
        i_wdt_cpu_model.wr_ctrl(8'h00);
        rchk("flagclr", ADDR_WDOG_CTRL, 8'h00);
        `CHK("irqclr", 1'b0, wdogIrqReq)
        `CHK("noswrst", 0, rstSeen)
        $display("test lock done");
    endtask : t_lock
    // restart, full shortest interval, then the delayed reset and what survives it
    task automatic t_timeout;
        i_wdt_cpu_model.wr_ctrl(8'h03);
        rchk("rsten", ADDR_WDOG_CTRL, 8'h02);
        n = 2;
        while (wdogIrqReq !== 1'b1 && n < 132000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("interval", 1'b1, n >= IVL_SEL0 - 1 && n <= IVL_SEL0 + 1)
        `CHK("early", 0, rstSeen)
        n = 0;
        while (wdogResetReq !== 1'b1 && n < 600) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("delay", 1'b1, n >= RST_DELAY_CLKS && n <= RST_DELAY_CLKS + 1)
        repeat (2) @(posedge mclk);
        `CHK("onepulse", 1, rstSeen)
        i_wdt_cpu_model.rd(ADDR_WDOG_CTRL, d);
        `CHK("cause", 8'h06, d & 8'h06)
        rchk("keepsel", ADDR_CLK_CTRL, CLK_CTRL_RESET);
        i_wdt_cpu_model.wr_ctrl(8'h00);
        $display("test timeout done");
    endtask : t_timeout
    // counts, verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    // main sequence
    initial begin
        repeat (2) @(negedge mclk);
        arst_n = 1'b1;
        t_reset();
        t_lock();
        t_timeout();
        end_sim();
    end
    // hang guard sized above the single full interval the run waits through
    initial begin
        repeat (135000) @(posedge mclk);
        failures++;
        end_sim();
    end
endmodule : watchdog_timer_unit_test
